// ===== logic/pbc_consts.svh
// Constants for the basic control register block: offsets, bit positions,
// reset values and timing counts. Definitions only.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

`define PBC_ADDR_W 5
`define PBC_OFS_CONTROL 5'h00
`define PBC_OFS_STATUS 5'h01

`define PBC_BIT_RESET 15
`define PBC_BIT_LOOPBACK 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_AN_EN 12
`define PBC_BIT_PWDN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_AN_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COL_TEST 7

`define PBC_CONTROL_RESET 16'h3000
`define PBC_STATUS_RESET 16'h7849
`define PBC_STATUS_AN_DONE_BIT 5
`define PBC_STATUS_LINK_BIT 2

`define PBC_CLK_MHZ 100
`define PBC_SOFT_RESET_NS 1000
`define PBC_SOFT_RESET_CYC ((`PBC_SOFT_RESET_NS * `PBC_CLK_MHZ) / 1000)
`define PBC_BIT_NS_100M 10
`define PBC_BIT_NS_10M 100
`define PBC_BIT_CYC_100M ((`PBC_BIT_NS_100M * `PBC_CLK_MHZ) / 1000)
`define PBC_BIT_CYC_10M ((`PBC_BIT_NS_10M * `PBC_CLK_MHZ) / 1000)
`define PBC_COL_ASSERT_BITS 512
`define PBC_COL_DELAY_BITS 16
`define PBC_COL_RELEASE_BITS 4

`endif

// ===== logic/pbc_pkg.sv
// Types shared by the basic control register block.
// Assumes pbc_consts.svh is on the include path.
`include "pbc_consts.svh"

package pbc_pkg;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [`PBC_ADDR_W-1:0] addr;
		logic [15:0] wdata;
	} pbc_mgmt_req_t;

	typedef struct packed {
		logic speed_100;
		logic an_en;
		logic isolate;
		logic duplex_full;
	} pbc_strap_t;

	typedef struct packed {
		logic tx_en;
		logic [3:0] txd;
	} pbc_mii_tx_t;

	typedef struct packed {
		logic rx_dv;
		logic [3:0] rxd;
	} pbc_mii_rx_t;

	typedef enum logic [1:0] {
		PBC_SR_IDLE = 2'b00,
		PBC_SR_BUSY = 2'b01,
		PBC_SR_DONE = 2'b11
	} pbc_sr_state_t;

endpackage

// ===== logic/pbc_bit_tick.sv
// Bit-time enable: one-cycle pulse per line bit time at the chosen speed.
// Assumes a single clock; speed may change at any time, count carries on and ticks at once if past the new limit.
`timescale 1ns/10ps
`include "pbc_consts.svh"

module pbc_bit_tick #(
	parameter int CYC_100M = `PBC_BIT_CYC_100M,
	parameter int CYC_10M = `PBC_BIT_CYC_10M
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic speed_100,
	output logic tick
);

	logic [7:0] cnt_reg;
	logic [7:0] limit;

	assign limit = speed_100 ? 8'(CYC_100M - 1) : 8'(CYC_10M - 1);
	assign tick = (cnt_reg >= limit);

	always_ff @(posedge mclk) begin
		if (!rst_n || tick) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

endmodule

// ===== logic/pbc_col_test.sv
// Collision signal test: COL follows TX_EN with a short bit-time delay.
// Assumes a bit-time enable pulse from pbc_bit_tick.
`timescale 1ns/10ps
`include "pbc_consts.svh"

module pbc_col_test #(
	parameter int DELAY_BITS = `PBC_COL_DELAY_BITS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic tx_en,
	input wire logic bit_tick,
	output logic col
);

	logic [9:0] bits_reg;

	// Delay stays far below the allowed limit so slow speeds still comply
	always_ff @(posedge mclk) begin
		if (!rst_n || !enable || !tx_en) begin
			bits_reg <= 10'h000;
		end else if (bit_tick && bits_reg != 10'(DELAY_BITS)) begin
			bits_reg <= bits_reg + 10'h001;
		end
	end

	// Drop is one cycle after TX_EN falls, well inside the release window
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			col <= 1'b0;
		end else begin
			col <= enable && tx_en && (bits_reg == 10'(DELAY_BITS));
		end
	end

endmodule

// ===== logic/pbc_control.sv
// Basic mode control register of a 10/100 PHY, with its status neighbour.
// Assumes a decoded management port (one access per cycle) and straps
// that are stable while rst_n is low and for a cycle after it rises.
//
// How it works
// - Writing one to bit 15 resets PCS state; bit reads one until done.
// - Software reset leaves vendor-specific state alone.
// - Loopback bit returns MII transmit data to MII receive lines.
// - With negotiation off, the speed bit picks 10 or 100 Mbps.
// - Common-pinout mode with negotiation off takes speed from its strap.
// - Negotiation enabled ignores speed and duplex bits; otherwise they rule.
// - Negotiation enable loads from its strap in both pin modes.
// - Power-down bit powers the device down and cuts the MII off; the RMII master 50MHz clock keeps running.
// - Power-down is bit OR low pin; the low pin sets the bit.
// - Isolate cuts the MII off and stops the RMII master 50MHz clock.
// - Common-pinout mode loads the isolate bit from its strap.
// - Restart bit is ignored while negotiation is disabled.
// - Restart write re-initiates negotiation; bit reads one until initiated.
// - Software clearing the restart bit does not disturb running negotiation.
// - With negotiation off, the duplex bit picks half or full duplex.
// - Common-pinout mode loads the duplex bit from its strap.
// - Collision test asserts COL within 512 bit times of TX_EN.
// - Collision test drops COL within 4 bit times of TX_EN falling.
`timescale 1ns/10ps
`include "pbc_consts.svh"

module pbc_control #(
	parameter int SOFT_RESET_CYC = `PBC_SOFT_RESET_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire pbc_pkg::pbc_mgmt_req_t mgmt_req,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire logic pin_mode_basic,
	input wire pbc_pkg::pbc_strap_t strap,
	input wire logic interrupt_or_powerdown_pin_n,
	input wire logic rmii_master,
	input wire logic an_speed_100,
	input wire logic an_duplex_full,
	input wire logic an_initiated,
	input wire logic an_complete,
	input wire logic link_up,
	input wire pbc_pkg::pbc_mii_tx_t mii_tx,
	input wire pbc_pkg::pbc_mii_rx_t pcs_rx,
	output pbc_pkg::pbc_mii_rx_t mii_rx,
	output logic mii_col,
	output logic mii_out_en,
	output logic clk50_out_en,
	output logic pcs_reset,
	output logic an_restart,
	output logic power_down,
	output logic loopback,
	output logic speed_100,
	output logic duplex_full
);

	////////////////////////////////////////////////////////////////////////////
	// Straps and software reset sequencing

	logic strap_done_reg;
	logic strap_load;
	pbc_pkg::pbc_sr_state_t sr_state_reg;
	logic [15:0] sr_cnt_reg;
	logic wr_ctrl;
	logic sr_start;
	logic sr_busy;
	logic sr_finish;

	assign wr_ctrl = mgmt_req.wr_en && (mgmt_req.addr == `PBC_OFS_CONTROL);
	assign sr_start = wr_ctrl && mgmt_req.wdata[`PBC_BIT_RESET];
	assign sr_busy = (sr_state_reg == pbc_pkg::PBC_SR_BUSY);
	assign sr_finish = sr_busy && (sr_cnt_reg == 16'(SOFT_RESET_CYC - 1));
	// Straps are caught on the first edge after release, and again when a
	// software reset finishes so the register returns to its strapped value
	assign strap_load = !strap_done_reg || sr_finish;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			strap_done_reg <= 1'b0;
		end else begin
			strap_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sr_state_reg <= pbc_pkg::PBC_SR_IDLE;
			sr_cnt_reg <= 16'h0000;
		end else begin
			case (sr_state_reg)
				pbc_pkg::PBC_SR_IDLE: begin
					sr_cnt_reg <= 16'h0000;
					if (sr_start) begin
						sr_state_reg <= pbc_pkg::PBC_SR_BUSY;
					end
				end
				pbc_pkg::PBC_SR_BUSY: begin
					sr_cnt_reg <= sr_cnt_reg + 16'h0001;
					if (sr_finish) begin
						sr_state_reg <= pbc_pkg::PBC_SR_DONE;
					end
				end
				pbc_pkg::PBC_SR_DONE: begin
					sr_state_reg <= pbc_pkg::PBC_SR_IDLE;
				end
				default: begin
					sr_state_reg <= pbc_pkg::PBC_SR_IDLE;
				end
			endcase
		end
	end

	// Only PCS logic sees this; vendor registers elsewhere never take it
	assign pcs_reset = sr_busy;

	////////////////////////////////////////////////////////////////////////////
	// Control fields

	logic loopback_reg;
	logic speed_reg;
	logic an_en_reg;
	logic pwdn_reg;
	logic isolate_reg;
	logic restart_reg;
	logic duplex_reg;
	logic col_test_reg;
	logic wr_live;
	logic restart_req;

	// Writes during reset are dropped; the reset bit still reads one
	assign wr_live = wr_ctrl && !sr_busy;

	always_ff @(posedge mclk) begin
		if (!rst_n || sr_busy) begin
			loopback_reg <= 1'b0;
			col_test_reg <= 1'b0;
		end else if (wr_live) begin
			loopback_reg <= mgmt_req.wdata[`PBC_BIT_LOOPBACK];
			col_test_reg <= mgmt_req.wdata[`PBC_BIT_COL_TEST];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			speed_reg <= 1'b1;
			an_en_reg <= 1'b1;
			isolate_reg <= 1'b0;
			duplex_reg <= 1'b0;
		end else if (strap_load) begin
			an_en_reg <= strap.an_en;
			speed_reg <= pin_mode_basic ? strap.speed_100 : 1'b1;
			isolate_reg <= pin_mode_basic ? strap.isolate : 1'b0;
			duplex_reg <= pin_mode_basic ? strap.duplex_full : 1'b0;
		end else if (wr_live) begin
			an_en_reg <= mgmt_req.wdata[`PBC_BIT_AN_EN];
			speed_reg <= mgmt_req.wdata[`PBC_BIT_SPEED];
			isolate_reg <= mgmt_req.wdata[`PBC_BIT_ISOLATE];
			duplex_reg <= mgmt_req.wdata[`PBC_BIT_DUPLEX];
		end
	end

	// Pin assertion wins over a software write of zero in the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwdn_reg <= 1'b0;
		end else if (!interrupt_or_powerdown_pin_n) begin
			pwdn_reg <= 1'b1;
		end else if (sr_busy) begin
			pwdn_reg <= 1'b0;
		end else if (wr_live) begin
			pwdn_reg <= mgmt_req.wdata[`PBC_BIT_PWDN];
		end
	end

	assign restart_req = wr_live && mgmt_req.wdata[`PBC_BIT_AN_RESTART]
		&& mgmt_req.wdata[`PBC_BIT_AN_EN] && an_en_reg;

	// Initiation clears the bit; a fresh request in that cycle keeps it set
	always_ff @(posedge mclk) begin
		if (!rst_n || sr_busy || !an_en_reg) begin
			restart_reg <= 1'b0;
		end else if (restart_req) begin
			restart_reg <= 1'b1;
		end else if (an_initiated) begin
			restart_reg <= 1'b0;
		end else if (wr_live) begin
			restart_reg <= mgmt_req.wdata[`PBC_BIT_AN_RESTART];
		end
	end

	// One pulse per request; a later clear of the bit cannot recall it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			an_restart <= 1'b0;
		end else begin
			an_restart <= restart_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective mode outputs

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			speed_100 <= 1'b1;
			duplex_full <= 1'b0;
			power_down <= 1'b0;
			loopback <= 1'b0;
			mii_out_en <= 1'b1;
			clk50_out_en <= 1'b1;
		end else begin
			speed_100 <= an_en_reg ? an_speed_100 : speed_reg;
			duplex_full <= an_en_reg ? an_duplex_full : duplex_reg;
			power_down <= pwdn_reg || !interrupt_or_powerdown_pin_n;
			loopback <= loopback_reg;
			mii_out_en <= !isolate_reg && !pwdn_reg;
			clk50_out_en <= !(isolate_reg && rmii_master);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// MII receive path with loopback, and collision test

	logic bit_tick;

	always_ff @(posedge mclk) begin
		if (!rst_n || !mii_out_en) begin
			mii_rx <= '0;
		end else if (loopback_reg) begin
			mii_rx.rx_dv <= mii_tx.tx_en;
			mii_rx.rxd <= mii_tx.txd;
		end else begin
			mii_rx <= pcs_rx;
		end
	end

	pbc_bit_tick u_bit_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.speed_100(speed_100),
		.tick(bit_tick)
	);

	pbc_col_test u_col_test (
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(col_test_reg && mii_out_en),
		.tx_en(mii_tx.tx_en),
		.bit_tick(bit_tick),
		.col(mii_col)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register read-back

	logic [15:0] ctrl_view;
	logic [15:0] status_view;

	always_comb begin
		ctrl_view = 16'h0000;
		ctrl_view[`PBC_BIT_RESET] = sr_busy;
		ctrl_view[`PBC_BIT_LOOPBACK] = loopback_reg;
		ctrl_view[`PBC_BIT_SPEED] = speed_reg;
		ctrl_view[`PBC_BIT_AN_EN] = an_en_reg;
		ctrl_view[`PBC_BIT_PWDN] = pwdn_reg;
		ctrl_view[`PBC_BIT_ISOLATE] = isolate_reg;
		ctrl_view[`PBC_BIT_AN_RESTART] = restart_reg;
		ctrl_view[`PBC_BIT_DUPLEX] = duplex_reg;
		ctrl_view[`PBC_BIT_COL_TEST] = col_test_reg;
		status_view = `PBC_STATUS_RESET;
		status_view[`PBC_STATUS_AN_DONE_BIT] = an_complete;
		status_view[`PBC_STATUS_LINK_BIT] = link_up;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mgmt_rdata <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else begin
			mgmt_rvalid <= mgmt_req.rd_en;
			if (mgmt_req.rd_en) begin
				case (mgmt_req.addr)
					`PBC_OFS_CONTROL: begin
						mgmt_rdata <= ctrl_view;
					end
					`PBC_OFS_STATUS: begin
						mgmt_rdata <= status_view;
					end
					default: begin
						mgmt_rdata <= 16'h0000;
					end
				endcase
			end
		end
	end

endmodule

// ===== dv/pbc_control_asserts.sv
// Port checker for pbc_control, bound to every instance.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
module pbc_control_asserts #(
	parameter int SOFT_RESET_CYC = 100
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire pbc_pkg::pbc_mgmt_req_t mgmt_req,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	input wire logic interrupt_or_powerdown_pin_n,
	input wire pbc_pkg::pbc_mii_tx_t mii_tx,
	input wire pbc_pkg::pbc_mii_rx_t mii_rx,
	input wire logic mii_col,
	input wire logic mii_out_en,
	input wire logic pcs_reset,
	input wire logic an_restart,
	input wire logic power_down,
	input wire logic loopback
);
	localparam int SR_MAX = SOFT_RESET_CYC + 2;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////
	// Only counts when idle, since writes during a running reset are dropped
	sequence s_sw_reset;
		mgmt_req.wr_en && mgmt_req.addr == 5'h00 && mgmt_req.wdata[15]
			&& !pcs_reset && !$past(pcs_reset);
	endsequence
	sequence s_an_off_wr;
		mgmt_req.wr_en && mgmt_req.addr == 5'h00 && !mgmt_req.wdata[12];
	endsequence
	chk_pwdn_pin: assert property (!interrupt_or_powerdown_pin_n |=> power_down)
		else $error("pin low without power down");
	chk_pwdn_mii: assert property ($rose(power_down) |-> ##[0:1] !mii_out_en)
		else $error("MII still driven in power down");
	chk_loop_data: assert property (loopback && $past(loopback) && $past(loopback, 2)
		&& mii_out_en && $past(mii_out_en) |-> {mii_rx} == {$past(mii_tx)})
		else $error("loopback data wrong");
	chk_col_cause: assert property ($rose(mii_col) |-> $past(mii_tx.tx_en))
		else $error("COL without TX_EN");
	chk_col_release: assert property ($fell(mii_tx.tx_en) |=> !mii_col)
		else $error("COL held after TX_EN fell");
	chk_rst_start: assert property (s_sw_reset |=> pcs_reset)
		else $error("software reset not started");
	chk_rst_ends: assert property (pcs_reset |-> ##[1:SR_MAX] !pcs_reset)
		else $error("software reset never ends");
	chk_an_ignored: assert property (s_an_off_wr |=> !an_restart)
		else $error("restart with negotiation off");
	chk_rsvd_zero: assert property (mgmt_rvalid && $past(mgmt_req.addr) == 5'h00
		|-> mgmt_rdata[6:0] == 7'h00)
		else $error("reserved bits not zero");
endmodule
bind pbc_control pbc_control_asserts #(.SOFT_RESET_CYC(SOFT_RESET_CYC)) u_chk (.mclk, .rst_n,
	.mgmt_req, .mgmt_rdata, .mgmt_rvalid, .interrupt_or_powerdown_pin_n, .mii_tx, .mii_rx,
	.mii_col, .mii_out_en, .pcs_reset, .an_restart, .power_down, .loopback);

// ===== dv/pbc_neg_model.sv
// Stand-in for the negotiation engine and receive path of pbc_control.
// Assumes one clock; the bench sets the answer delay on dly.
`timescale 1ns/10ps
module pbc_neg_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] dly,
	input wire logic an_restart,
	output logic an_initiated,
	output pbc_pkg::pbc_mii_rx_t pcs_rx
);
	logic [3:0] cnt_reg;
	////////////////////////////////
	// Inverts every cycle so a stale sample never passes for data
	always_ff @(posedge mclk) begin
		if (!rst_n)
			pcs_rx <= 5'h15;
		else
			pcs_rx <= ~pcs_rx;
	end
	// A later clear of the restart bit does not cancel the countdown
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cnt_reg <= 4'h0;
		else if (an_restart)
			cnt_reg <= dly;
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
	end
	assign an_initiated = cnt_reg == 4'h1;
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for pbc_control with a negotiation stand-in.
// Assumes the checker binds itself to the design.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
	localparam int SRC = 8;
	logic mclk = 1'b0, rst_n = 1'b0, basic = 1'b1, pin_n = 1'b1, rmii = 1'b0;
	logic an_spd = 1'b0, an_dup = 1'b0, an_done = 1'b0, link = 1'b0;
	logic [3:0] dly = 4'h2;
	logic [31:0] seed = 32'he7b7801b;
	logic [15:0] rdata, got, w;
	logic rvalid, an_init, col, out_en, c50, pcs_rst, an_rst, pwdn, lpb, spd, dup;
	pbc_pkg::pbc_mgmt_req_t req = '0;
	pbc_pkg::pbc_strap_t strap = 4'h0;
	logic ten = 1'b0;
	logic [3:0] txd = 4'h0;
	pbc_pkg::pbc_mii_tx_t tx;
	pbc_pkg::pbc_mii_rx_t prx, mrx;
	int n_mismatch = 0, tests_run = 0, n, k;
	////////////////////////////////
	pbc_control #(.SOFT_RESET_CYC(SRC)) dut (.mclk(mclk), .rst_n(rst_n), .mgmt_req(req),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .pin_mode_basic(basic), .strap(strap),
		.interrupt_or_powerdown_pin_n(pin_n), .rmii_master(rmii), .an_speed_100(an_spd),
		.an_duplex_full(an_dup), .an_initiated(an_init), .an_complete(an_done),
		.link_up(link), .mii_tx(tx), .pcs_rx(prx), .mii_rx(mrx), .mii_col(col),
		.mii_out_en(out_en), .clk50_out_en(c50), .pcs_reset(pcs_rst), .an_restart(an_rst),
		.power_down(pwdn), .loopback(lpb), .speed_100(spd), .duplex_full(dup));
	pbc_neg_model partner (.mclk(mclk), .rst_n(rst_n), .dly(dly), .an_restart(an_rst),
		.an_initiated(an_init), .pcs_rx(prx));
	// Transmit fields come from two processes, so they meet here once
	assign tx = '{ten, txd};
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		seed <= (seed >> 1) ^ (seed[0] ? 32'h80200003 : 32'h0);
		txd <= seed[3:0];
	end
	////////////////////////////////
	function automatic logic [15:0] sval(input pbc_pkg::pbc_strap_t s, input logic b);
		return {2'b00, b ? s.speed_100 : 1'b1, s.an_en, 1'b0, b & s.isolate, 1'b0,
			b & s.duplex_full, 8'h00};
	endfunction
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		req <= '0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [4:0] a);
		req <= '{1'b0, 1'b1, a, 16'h0};
		@(posedge mclk);
		req <= '0;
		#1 got = rdata;
		@(posedge mclk);
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
		rd(a);
		`CHK(got, e)
	endtask
	task automatic do_reset(input logic b, input pbc_pkg::pbc_strap_t s);
		rst_n <= 1'b0;
		basic <= b;
		strap <= s;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask
	task automatic close_out();
		$display("mismatches %0d, checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#200us;
		n_mismatch++;
		close_out();
	end
	////////////////////////////////
	initial begin
		@(posedge mclk);
		for (k = 0; k < 4; k++) begin
			an_done <= seed[9];
			link <= seed[10];
			do_reset(k[0], seed[7:4]);
			chk_rd(5'h00, sval(strap, basic));
			chk_rd(5'h01, 16'h7849 | {10'h0, an_done, 2'h0, link, 2'h0});
		end
		for (k = 0; k < 8; k++) begin
			w = seed[15:0] & 16'h7dff;
			rmii <= seed[16];
			an_spd <= seed[17];
			an_dup <= seed[18];
			wr(5'h00, w);
			chk_rd(5'h00, w & 16'h7d80);
			#1;
			`CHK(spd, w[12] ? an_spd : w[13])
			`CHK(dup, w[12] ? an_dup : w[8])
			`CHK(pwdn, w[11])
			`CHK({out_en, c50}, {~(w[10] | w[11]), ~(w[10] & rmii)})
			`CHK(lpb, w[14])
			@(posedge mclk);
		end
		wr(5'h00, 16'h6000);
		wr(5'h16, 16'h0004);
		chk_rd(5'h16, 16'h0000);
		chk_rd(5'h00, 16'h6000);
		// Restart is only honoured once negotiation is already enabled
		wr(5'h00, 16'h1000);
		dly <= 4'h9;
		wr(5'h00, 16'h1200);
		chk_rd(5'h00, 16'h1200);
		n = 0;
		while (!an_init && n < 40) begin
			@(posedge mclk);
			n++;
		end
		repeat (2) @(posedge mclk);
		chk_rd(5'h00, 16'h1000);
		// Clearing the bit mid-way must not stop the negotiation already started
		wr(5'h00, 16'h1200);
		wr(5'h00, 16'h1000);
		n = 0;
		while (!an_init && n < 40) begin
			@(posedge mclk);
			n++;
		end
		`CHK(n < 40, 1'b1)
		repeat (2) @(posedge mclk);
		wr(5'h00, 16'h0200);
		chk_rd(5'h00, 16'h0000);
		pin_n <= 1'b0;
		@(posedge mclk);
		pin_n <= 1'b1;
		@(posedge mclk);
		chk_rd(5'h00, 16'h0800);
		wr(5'h00, 16'h8000);
		rd(5'h00);
		`CHK({got[15], pcs_rst}, 2'b11)
		wr(5'h00, 16'h0100);
		repeat (SRC) @(posedge mclk);
		chk_rd(5'h00, sval(strap, basic));
		for (k = 0; k < 2; k++) begin
			wr(5'h00, {2'b00, k[0], 13'h0080});
			ten <= 1'b1;
			n = 0;
			while (!col && n < 6000) begin
				@(posedge mclk);
				n++;
			end
			`CHK(n <= (k[0] ? 512 : 5120), 1'b1)
			ten <= 1'b0;
			repeat (k[0] ? 4 : 40) @(posedge mclk);
			#1;
			`CHK(col, 1'b0)
			@(posedge mclk);
		end
		close_out();
	end
endmodule
